//--- velocity_scaled_coil_pwm_tb_top.sv
// Self-checking bench of the velocity scaled coil PWM block.
`timescale 1ns/1ps
module velocity_scaled_coil_pwm_tb_top
    import vscp_pkg::*;
;
    logic aclk = 0, aresetn = 0, step_pulse = 0, step_dir = 0;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0;
    logic spi_data_out = 0, spi_select_n = 1;
    logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [DATA_W-1:0] s_axi_wdata = '0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic signed [31:0] ramp_velocity = 0;
    logic signed [ENTRY_W-1:0] sine_entry = 0, cosine_entry = 0;
    logic coil_a_wave_pin, coil_b_wave_pin;
    logic driver_data_out_pin, driver_select_pin;
    logic [31:0] per_q, hi_a_q, hi_b_q;
    int err_count = 0, checked = 0;

    vscp_top dut_u (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
        .s_axi_awaddr, .s_axi_awprot, .s_axi_wvalid, .s_axi_wready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready,
        .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr,
        .s_axi_arprot, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
        .s_axi_rresp, .step_pulse, .step_dir, .ramp_velocity,
        .sine_entry, .cosine_entry, .spi_data_out, .spi_select_n,
        .coil_a_wave_pin, .coil_b_wave_pin, .driver_data_out_pin,
        .driver_select_pin);
    vscp_drv_model mdl_u (.aclk, .wave_a(coil_a_wave_pin),
        .wave_b(coil_b_wave_pin), .per_q, .hi_a_q, .hi_b_q);

    initial forever #50 aclk = ~aclk;

    task automatic chk(input logic [31:0] g, e, input string m);
        checked++;
        if (g !== e)
        begin
            err_count++;
            $display("CHECK FAILED at %0t: %s", $time, m);
        end
    endtask : chk

    task automatic wr(input logic [7:0] i, input logic [31:0] d,
                      input logic [1:0] er);
        @(posedge aclk);
        s_axi_awaddr <= {i, 2'b00};
        s_axi_wdata <= d;
        s_axi_awvalid <= 1;
        s_axi_wvalid <= 1;
        s_axi_bready <= 1;
        repeat (50)
        begin
            @(posedge aclk);
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 0;
            if (s_axi_bvalid === 1'b1) break;
        end
        s_axi_bready <= 0;
        chk({s_axi_bvalid, s_axi_bresp}, {1'b1, er}, "write response");
    endtask : wr

    task automatic rdc(input logic [7:0] i, input logic [31:0] e,
                       input logic [1:0] er);
        @(posedge aclk);
        s_axi_araddr <= {i, 2'b00};
        s_axi_arvalid <= 1;
        s_axi_rready <= 1;
        repeat (50)
        begin
            @(posedge aclk);
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 0;
            if (s_axi_rvalid === 1'b1) break;
        end
        s_axi_rready <= 0;
        chk({s_axi_rvalid, s_axi_rresp}, {1'b1, er}, "read response");
        chk(s_axi_rdata, e, "read data");
    endtask : rdc

    task automatic t_regs;
        rdc(IDX_GLOBAL_SETUP, 32'h0, RESP_OKAY);
        wr(IDX_PERIOD_CYCLES, 32'h14, RESP_OKAY);
        rdc(IDX_PERIOD_CYCLES, 32'h14, RESP_OKAY);
        rdc(8'h30, 32'h0, RESP_SLVERR);
        wr(8'h30, 32'hFF, RESP_SLVERR);
        $display("test regs done");
    endtask : t_regs

    task automatic t_step;
        for (int k = 0; k < 2; k++)
        begin
            @(posedge aclk);
            step_pulse <= k[0];
            step_dir <= !k[0];
            repeat (3) @(posedge aclk);
            chk({coil_a_wave_pin, coil_b_wave_pin}, {k[0], !k[0]}, "s/d");
        end
        $display("test step done");
    endtask : t_step

    task automatic t_wave;
        sine_entry <= 9'sh080;
        cosine_entry <= -9'sh080;
        wr(IDX_GLOBAL_SETUP, 32'h0020_0000, RESP_OKAY);
        repeat (120) @(posedge aclk);
        chk(per_q, 32'h14, "period");
        chk(hi_a_q, 32'hF, "coil a duty");
        chk(hi_b_q, 32'h5, "coil b duty");
        $display("test wave done");
    endtask : t_wave

    task automatic t_scale;
        logic signed [31:0] v[5] = '{32'sh0, 32'sh1F4, -32'sh1F4,
                                     32'sh3E8, 32'sh7D0};
        logic [31:0] e[5] = '{32'h8000, 32'hC000, 32'hC000,
                              32'h10000, 32'h10000};
        wr(IDX_FULL_SCALE_VEL, 32'h3E8, RESP_OKAY);
        wr(IDX_CURRENT_SETUP, 32'h7FFF_0100, RESP_OKAY);
        for (int k = 0; k < 5; k++)
        begin
            ramp_velocity <= v[k];
            repeat (120) @(posedge aclk);
            rdc(IDX_SCALE_STATUS, e[k], RESP_OKAY);
            if (k == 0) chk(hi_a_q, 32'hC, "standstill duty");
        end
        $display("test scale done");
    endtask : t_scale

    task automatic t_hold;
        ramp_velocity <= 0;
        wr(IDX_HOLD_SETUP, 32'h13F, RESP_OKAY);
        repeat (60) @(posedge aclk);
        rdc(IDX_SCALE_STATUS, 32'h4000, RESP_OKAY);
        wr(IDX_HOLD_SETUP, 32'h0, RESP_OKAY);
        $display("test hold done");
    endtask : t_hold

    task automatic t_route;
        logic [3:0] f[3] = '{FMT_WAVE_A, FMT_WAVE_B, 4'h0};
        for (int k = 0; k < 3; k++)
        begin
            spi_data_out <= k[0];
            spi_select_n <= !k[0];
            wr(IDX_LINK_SETUP, 32'(f[k]), RESP_OKAY);
            repeat (40)
            begin
                @(posedge aclk);
                if (k < 2)
                    chk({driver_data_out_pin, driver_select_pin},
                        {coil_a_wave_pin, coil_b_wave_pin}, "routed");
                else
                    chk({driver_data_out_pin, driver_select_pin},
                        {spi_data_out, spi_select_n}, "pass");
            end
        end
        $display("test route done");
    endtask : t_route

    task automatic give_verdict;
        $display("checked %0d, err_count %0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : give_verdict

    initial
    begin
        repeat (20) @(posedge aclk);
        aresetn <= 1;
        repeat (2) @(posedge aclk);
        t_regs;
        t_step;
        t_wave;
        t_scale;
        t_hold;
        t_route;
        give_verdict;
    end

    initial
    begin
        repeat (20000) @(posedge aclk);
        err_count++;
        $display("CHECK FAILED at %0t: watchdog", $time);
        give_verdict;
    end
endmodule : velocity_scaled_coil_pwm_tb_top

//--- vscp_drv_model.sv
// Model of the driver stage inputs, measuring wave period and high times.
`timescale 1ns/1ps
module vscp_drv_model (
    // Clock
    input  wire logic        aclk,
    // Coil waves
    input  wire logic        wave_a,
    input  wire logic        wave_b,
    // Last measured window
    output logic      [31:0] per_q,
    output logic      [31:0] hi_a_q,
    output logic      [31:0] hi_b_q
);
    logic        prev_q = 1'b0;
    logic [31:0] cnt_q  = 32'h0;
    logic [31:0] ha_q   = 32'h0;
    logic [31:0] hb_q   = 32'h0;

    // A window runs from one rising edge of coil A to the next.
    always_ff @(posedge aclk)
    begin
        prev_q <= wave_a;
        if (wave_a && !prev_q)
        begin
            per_q  <= cnt_q;
            hi_a_q <= ha_q;
            hi_b_q <= hb_q;
            cnt_q  <= 32'h1;
            ha_q   <= 32'h1;
            hb_q   <= 32'(wave_b);
        end
        else
        begin
            cnt_q <= cnt_q + 32'h1;
            ha_q  <= ha_q + 32'(wave_a);
            hb_q  <= hb_q + 32'(wave_b);
        end
    end
endmodule : vscp_drv_model

//--- vscp_pkg.sv
// Shared constants and types of the velocity scaled coil PWM block.
package vscp_pkg;

    // Bus geometry.
    localparam int unsigned ADDR_W   = 10;
    localparam int unsigned DATA_W   = 32;

    // Register indices; the byte address is four times the index.
    localparam logic [7:0] IDX_GLOBAL_SETUP   = 8'h00;
    localparam logic [7:0] IDX_CURRENT_SETUP  = 8'h05;
    localparam logic [7:0] IDX_FULL_SCALE_VEL = 8'h17;
    localparam logic [7:0] IDX_PERIOD_CYCLES  = 8'h1F;
    localparam logic [7:0] IDX_LINK_SETUP     = 8'h20;
    localparam logic [7:0] IDX_HOLD_SETUP     = 8'h21;
    localparam logic [7:0] IDX_SCALE_STATUS   = 8'h22;

    // Field positions.
    localparam int unsigned PWM_OUT_EN_BIT = 21;
    localparam int unsigned SCALE_EN_BIT   = 8;
    localparam int unsigned AMPL_LSB       = 16;
    localparam int unsigned HOLD_EN_BIT    = 8;

    // Reset values.
    localparam logic [31:0] RST_WORD = 32'h0000_0000;
    localparam logic [3:0]  RST_FMT  = 4'h0;
    localparam logic [8:0]  RST_HOLD = 9'h000;

    // Driver link formats that carry the coil waves on the driver pins.
    localparam logic [3:0] FMT_WAVE_A = 4'h8;
    localparam logic [3:0] FMT_WAVE_B = 4'h9;

    // Scale factor as a numerator over two to the power 17; 0.5 is full.
    localparam logic [16:0] SCALE_FULL = 17'h10000;
    localparam logic [16:0] HOLD_STEP  = 17'h00100;
    localparam logic [4:0]  DIV_STEPS  = 5'h10;

    // Table entry width and the total shift of the duty product.
    localparam int unsigned ENTRY_W    = 9;
    localparam int unsigned DUTY_SHIFT = 25;

    // Bus responses.
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {SC_IDLE, SC_DIV, SC_APPLY} vscp_scale_state_t;

endpackage : vscp_pkg

//--- vscp_top.sv
// Velocity scaled coil PWM generator with its register slave.
//
// Overview of operation
// - Pwm select clear: motion outputs carry step pulses and direction.
// - Pwm select set: coil A and coil B waves replace step/direction.
// - One wave period lasts exactly the programmed number of clock cycles, and one cycle when zero is programmed.
// - Coil A duty follows the sine entry, coil B the cosine entry.
// - Current setup bit 8 enables scaling; bits 31:16 hold standstill amplitude.
// - At zero velocity scale equals standstill amplitude plus one over 2^17.
// - Scale rises linearly with velocity, reaching 0.5 at full-scale velocity.
// - Duty stays between one half minus and one half plus the scale.
// - With scaling and hold scaling enabled, standstill uses the standstill hold value.
// - With matching driver selected, waves also go to driver pins.
// - Link format 1000 or 1001 plus pwm select routes waves to driver pins.
`timescale 1ns/1ps
module vscp_top
    import vscp_pkg::*;
(
    // Clock and reset
    input  wire logic                      aclk,
    input  wire logic                      aresetn,
    // Register bus write address
    input  wire logic                      s_axi_awvalid,
    output logic                           s_axi_awready,
    input  wire logic [ADDR_W-1:0]         s_axi_awaddr,
    input  wire logic [2:0]                s_axi_awprot,
    // Register bus write data
    input  wire logic                      s_axi_wvalid,
    output logic                           s_axi_wready,
    input  wire logic [DATA_W-1:0]         s_axi_wdata,
    input  wire logic [3:0]                s_axi_wstrb,
    // Register bus write response
    output logic                           s_axi_bvalid,
    input  wire logic                      s_axi_bready,
    output logic [1:0]                     s_axi_bresp,
    // Register bus read
    input  wire logic                      s_axi_arvalid,
    output logic                           s_axi_arready,
    input  wire logic [ADDR_W-1:0]         s_axi_araddr,
    input  wire logic [2:0]                s_axi_arprot,
    output logic                           s_axi_rvalid,
    input  wire logic                      s_axi_rready,
    output logic [DATA_W-1:0]              s_axi_rdata,
    output logic [1:0]                     s_axi_rresp,
    // Motion core
    input  wire logic                      step_pulse,
    input  wire logic                      step_dir,
    input  wire logic signed [31:0]        ramp_velocity,
    input  wire logic signed [ENTRY_W-1:0] sine_entry,
    input  wire logic signed [ENTRY_W-1:0] cosine_entry,
    // Driver link
    input  wire logic                      spi_data_out,
    input  wire logic                      spi_select_n,
    // Pins
    output logic                           coil_a_wave_pin,
    output logic                           coil_b_wave_pin,
    output logic                           driver_data_out_pin,
    output logic                           driver_select_pin
);
    // Registers.
    logic [31:0] global_setup_q;
    logic [31:0] current_setup_q;
    logic [31:0] full_scale_velocity_q;
    logic [31:0] period_cycles_q;
    logic [3:0]  link_format_q;
    logic [8:0]  hold_setup_q;

    // Bus state.
    logic        aw_held_q;
    logic [7:0]  aw_idx_q;
    logic        w_held_q;
    logic [31:0] wdata_q;
    logic [3:0]  wstrb_q;
    logic        do_write;
    logic        wr_hit;
    logic        rd_hit;
    logic [31:0] rd_val;
    logic [7:0]  ar_idx;

    // Scale state.
    vscp_scale_state_t sc_state_q;
    logic [31:0] vel_abs;
    logic [31:0] vel_abs_q;
    logic [32:0] rem_q;
    logic [32:0] rem_sh;
    logic [16:0] frac_q;
    logic [4:0]  step_q;
    logic [16:0] live_scale_q;
    logic [16:0] scale_d;
    logic [16:0] ampl_p1;
    logic [33:0] span_prod;
    logic [17:0] interp;

    // Wave state.
    logic [31:0] cnt_q;
    logic        wrap;
    logic        wave_a;
    logic        wave_b;
    logic        pwm_sel;
    logic        scale_en;
    logic        hold_en;
    logic        drv_route;

    assign pwm_sel  = global_setup_q[PWM_OUT_EN_BIT];
    assign scale_en = current_setup_q[SCALE_EN_BIT];
    assign hold_en  = hold_setup_q[HOLD_EN_BIT];
    assign ar_idx   = s_axi_araddr[ADDR_W-1:2];

    // Byte lane merge of a register write.
    function automatic logic [31:0] vscp_merge(
        input logic [31:0] old_v,
        input logic [31:0] new_v,
        input logic [3:0]  strb
    );
        logic [31:0] res;
        res = old_v;
        for (int i = 0; i < 4; i++)
        begin
            if (strb[i])
                res[8*i +: 8] = new_v[8*i +: 8];
        end
        return res;
    endfunction : vscp_merge

    // Write address and data are held separately, in either order.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held_q     <= 1'b0;
            aw_idx_q      <= 8'h00;
            s_axi_awready <= 1'b0;
        end
        else if (s_axi_awvalid && s_axi_awready)
        begin
            aw_held_q     <= 1'b1;
            aw_idx_q      <= s_axi_awaddr[ADDR_W-1:2];
            s_axi_awready <= 1'b0;
        end
        else if (s_axi_bvalid && s_axi_bready)
        begin
            aw_held_q     <= 1'b0;
            s_axi_awready <= 1'b1;
        end
        else if (!aw_held_q)
            s_axi_awready <= 1'b1;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            w_held_q     <= 1'b0;
            wdata_q      <= RST_WORD;
            wstrb_q      <= 4'h0;
            s_axi_wready <= 1'b0;
        end
        else if (s_axi_wvalid && s_axi_wready)
        begin
            w_held_q     <= 1'b1;
            wdata_q      <= s_axi_wdata;
            wstrb_q      <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
        end
        else if (s_axi_bvalid && s_axi_bready)
        begin
            w_held_q     <= 1'b0;
            s_axi_wready <= 1'b1;
        end
        else if (!w_held_q)
            s_axi_wready <= 1'b1;
    end

    assign do_write = aw_held_q && w_held_q && !s_axi_bvalid;
    assign wr_hit   = (aw_idx_q == IDX_GLOBAL_SETUP)
                   || (aw_idx_q == IDX_CURRENT_SETUP)
                   || (aw_idx_q == IDX_FULL_SCALE_VEL)
                   || (aw_idx_q == IDX_PERIOD_CYCLES)
                   || (aw_idx_q == IDX_LINK_SETUP)
                   || (aw_idx_q == IDX_HOLD_SETUP);

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
        end
        else if (do_write)
        begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
        end
        else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            global_setup_q        <= RST_WORD;
            current_setup_q       <= RST_WORD;
            full_scale_velocity_q <= RST_WORD;
            period_cycles_q       <= RST_WORD;
            link_format_q         <= RST_FMT;
            hold_setup_q          <= RST_HOLD;
        end
        else if (do_write)
        begin
            unique case (aw_idx_q)
                IDX_GLOBAL_SETUP:
                    global_setup_q <= vscp_merge(global_setup_q, wdata_q,
                                                 wstrb_q);
                IDX_CURRENT_SETUP:
                    current_setup_q <= vscp_merge(current_setup_q, wdata_q,
                                                  wstrb_q);
                IDX_FULL_SCALE_VEL:
                    full_scale_velocity_q <= vscp_merge(
                        full_scale_velocity_q, wdata_q, wstrb_q);
                IDX_PERIOD_CYCLES:
                    period_cycles_q <= vscp_merge(period_cycles_q, wdata_q,
                                                  wstrb_q);
                IDX_LINK_SETUP:
                    if (wstrb_q[0])
                        link_format_q <= wdata_q[3:0];
                IDX_HOLD_SETUP:
                    hold_setup_q <= 9'(vscp_merge({23'h0, hold_setup_q},
                                                  wdata_q, wstrb_q));
                default:
                    hold_setup_q <= hold_setup_q;
            endcase
        end
    end

    // Read data selection; unmapped addresses answer with an error.
    always_comb
    begin
        rd_hit = 1'b1;
        rd_val = RST_WORD;
        unique case (ar_idx)
            IDX_GLOBAL_SETUP:   rd_val = global_setup_q;
            IDX_CURRENT_SETUP:  rd_val = current_setup_q;
            IDX_FULL_SCALE_VEL: rd_val = full_scale_velocity_q;
            IDX_PERIOD_CYCLES:  rd_val = period_cycles_q;
            IDX_LINK_SETUP:     rd_val = {28'h0, link_format_q};
            IDX_HOLD_SETUP:     rd_val = {23'h0, hold_setup_q};
            IDX_SCALE_STATUS:   rd_val = {15'h0, live_scale_q};
            default:            rd_hit = 1'b0;
        endcase
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= RST_WORD;
            s_axi_rresp   <= RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= rd_val;
            s_axi_rresp   <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        end
        else if (s_axi_rvalid && s_axi_rready)
        begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end
        else if (!s_axi_rvalid)
            s_axi_arready <= 1'b1;
    end

    assign vel_abs = ramp_velocity[31] ? 32'(-ramp_velocity)
                                       : 32'(ramp_velocity);
    assign rem_sh  = {rem_q[31:0], 1'b0};

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            sc_state_q <= SC_IDLE;
            vel_abs_q  <= RST_WORD;
            rem_q      <= 33'h0;
            frac_q     <= 17'h0;
            step_q     <= 5'h0;
        end
        else
        begin
            unique case (sc_state_q)
                SC_IDLE:
                begin
                    vel_abs_q <= vel_abs;
                    rem_q     <= {1'b0, vel_abs};
                    step_q    <= 5'h0;
                    if (vel_abs == 32'h0)
                    begin
                        frac_q     <= 17'h0;
                        sc_state_q <= SC_APPLY;
                    end
                    else if (vel_abs >= full_scale_velocity_q)
                    begin
                        frac_q     <= SCALE_FULL;
                        sc_state_q <= SC_APPLY;
                    end
                    else
                    begin
                        frac_q     <= 17'h0;
                        sc_state_q <= SC_DIV;
                    end
                end
                SC_DIV:
                begin
                    if (rem_sh >= {1'b0, full_scale_velocity_q})
                    begin
                        rem_q  <= rem_sh - {1'b0, full_scale_velocity_q};
                        frac_q <= {frac_q[15:0], 1'b1};
                    end
                    else
                    begin
                        rem_q  <= rem_sh;
                        frac_q <= {frac_q[15:0], 1'b0};
                    end
                    step_q <= step_q + 5'h1;
                    if (step_q == DIV_STEPS - 5'h1)
                        sc_state_q <= SC_APPLY;
                end
                SC_APPLY:
                    sc_state_q <= SC_IDLE;
            endcase
        end
    end

    always_comb
    begin
        ampl_p1   = {1'b0, current_setup_q[AMPL_LSB +: 16]} + 17'h1;
        span_prod = 34'(SCALE_FULL - ampl_p1) * 34'(frac_q);
        interp    = 18'(ampl_p1) + span_prod[33:16];
        if (!scale_en)
            scale_d = SCALE_FULL;
        else if (hold_en && vel_abs_q == 32'h0)
            scale_d = 17'({hold_setup_q[7:0], 8'h00}) + HOLD_STEP;
        else
            scale_d = interp[16:0];
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            live_scale_q <= SCALE_FULL;
        else if (sc_state_q == SC_APPLY)
            live_scale_q <= scale_d;
    end

    assign wrap = (cnt_q + 32'h1 >= period_cycles_q);

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            cnt_q <= 32'h0;
        else if (wrap)
            cnt_q <= 32'h0;
        else
            cnt_q <= cnt_q + 32'h1;
    end

    vscp_wave_chan u_chan_a (
        .aclk    (aclk),
        .aresetn (aresetn),
        .wrap    (wrap),
        .count   (cnt_q),
        .period  (period_cycles_q),
        .scale   (live_scale_q),
        .entry   (sine_entry),
        .wave_q  (wave_a)
    );

    vscp_wave_chan u_chan_b (
        .aclk    (aclk),
        .aresetn (aresetn),
        .wrap    (wrap),
        .count   (cnt_q),
        .period  (period_cycles_q),
        .scale   (live_scale_q),
        .entry   (cosine_entry),
        .wave_q  (wave_b)
    );

    assign drv_route = pwm_sel && (link_format_q == FMT_WAVE_A
                                || link_format_q == FMT_WAVE_B);

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            coil_a_wave_pin <= 1'b0;
            coil_b_wave_pin <= 1'b0;
        end
        else
        begin
            coil_a_wave_pin <= pwm_sel ? wave_a : step_pulse;
            coil_b_wave_pin <= pwm_sel ? wave_b : step_dir;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            driver_data_out_pin <= 1'b0;
            driver_select_pin   <= 1'b1;
        end
        else
        begin
            driver_data_out_pin <= drv_route ? wave_a : spi_data_out;
            driver_select_pin   <= drv_route ? wave_b : spi_select_n;
        end
    end

    sequence write_taken_s;
        do_write;
    endsequence

    sequence resp_held_s;
        s_axi_bvalid;
    endsequence

    write_resp_a: assert property (@(posedge aclk) disable iff (!aresetn)
        write_taken_s |=> resp_held_s)
        else $error("write response not raised");

    resp_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response not held");

    step_mode_a: assert property (@(posedge aclk) disable iff (!aresetn)
        $past(aresetn) && !$past(pwm_sel)
        |-> coil_a_wave_pin == $past(step_pulse)
            && coil_b_wave_pin == $past(step_dir))
        else $error("step outputs not forwarded");

    wave_mode_a: assert property (@(posedge aclk) disable iff (!aresetn)
        $past(aresetn) && $past(pwm_sel)
        |-> coil_a_wave_pin == $past(wave_a)
            && coil_b_wave_pin == $past(wave_b))
        else $error("coil waves not forwarded");

    period_wrap_a: assert property (@(posedge aclk) disable iff (!aresetn)
        wrap && period_cycles_q != 32'h0 && $stable(period_cycles_q)
        |-> cnt_q == period_cycles_q - 32'h1 ##1 cnt_q == 32'h0)
        else $error("period length wrong");

    standstill_scale_a: assert property (@(posedge aclk)
        disable iff (!aresetn)
        sc_state_q == SC_APPLY && scale_en && !hold_en
            && vel_abs_q == 32'h0
        |=> live_scale_q == $past(ampl_p1))
        else $error("standstill scale wrong");

    full_speed_a: assert property (@(posedge aclk) disable iff (!aresetn)
        sc_state_q == SC_APPLY && vel_abs_q != 32'h0
            && vel_abs_q >= full_scale_velocity_q
            && $stable(full_scale_velocity_q)
        |=> live_scale_q == SCALE_FULL)
        else $error("scale not saturated at full speed");

    scale_bound_a: assert property (@(posedge aclk) disable iff (!aresetn)
        live_scale_q <= SCALE_FULL)
        else $error("scale above one half");

    hold_scale_a: assert property (@(posedge aclk) disable iff (!aresetn)
        sc_state_q == SC_APPLY && scale_en && hold_en && vel_abs_q == 32'h0
        |=> live_scale_q == $past({1'b0, hold_setup_q[7:0], 8'h00}) + HOLD_STEP)
        else $error("hold scale not used at standstill");

    driver_route_a: assert property (@(posedge aclk) disable iff (!aresetn)
        $past(aresetn) && $past(drv_route)
        |-> driver_data_out_pin == $past(wave_a)
            && driver_select_pin == $past(wave_b))
        else $error("driver pins not carrying coil waves");

endmodule : vscp_top

//--- vscp_wave_chan.sv
// One coil wave channel: duty threshold and comparator.
`timescale 1ns/1ps
module vscp_wave_chan
    import vscp_pkg::*;
(
    // Clock and reset
    input  wire logic                      aclk,
    input  wire logic                      aresetn,
    // Period counter
    input  wire logic                      wrap,
    input  wire logic [31:0]               count,
    input  wire logic [31:0]               period,
    // Scale and table entry
    input  wire logic [16:0]               scale,
    input  wire logic signed [ENTRY_W-1:0] entry,
    // Wave
    output logic                           wave_q
);
    logic signed [60:0] prod;
    logic signed [60:0] thr_s;
    logic [31:0]        thr_d;
    logic [31:0]        thr_q;

    always_comb
    begin
        prod  = 61'(signed'({1'b0, period})) * 61'(signed'({1'b0, scale}))
              * 61'(entry);
        thr_s = signed'(61'(period >> 1)) + (prod >>> DUTY_SHIFT);
        if (thr_s < 0)
            thr_d = 32'h0000_0000;
        else if (thr_s > 61'(period))
            thr_d = period;
        else
            thr_d = thr_s[31:0];
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            thr_q <= 32'h0000_0000;
        else if (wrap)
            thr_q <= thr_d;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            wave_q <= 1'b0;
        else
            wave_q <= (count < thr_q);
    end

    wave_cmp_a: assert property (@(posedge aclk) disable iff (!aresetn)
        $past(aresetn) |-> wave_q == ($past(count) < $past(thr_q)))
        else $error("wave level does not follow the threshold");

endmodule : vscp_wave_chan
